// ### rtl/tsl_consts.svh
`ifndef TSL_CONSTS_SVH
`define TSL_CONSTS_SVH

// host access pages
`define TSL_PAGE_FRAMER 4'h0
`define TSL_PAGE_IRQ 4'ha

// direct data ports, low nibble of the channel-relative address
`define TSL_OFS_BUF0_PORT 4'h6
`define TSL_OFS_BUF1_PORT 4'h7

// indirect offsets, framer page
`define TSL_OFS_LINK_CONTROL 8'h13
`define TSL_OFS_TX_LINK_BYTE_COUNT 8'h14

// indirect offsets, interrupt page
`define TSL_OFS_BLOCK_IRQ_ENABLE 8'h00
`define TSL_OFS_IRQ_CONTROL 8'h01
`define TSL_OFS_LINK_STATUS 8'h06
`define TSL_OFS_LINK_IRQ_ENABLE 8'h07

// field positions
`define TSL_BIT_BUF_SELECT 7
`define TSL_BIT_MSG_MODE_EN 7
`define TSL_BIT_PACKET_EN 0
`define TSL_BIT_SOT_STATUS 6
`define TSL_BIT_SOT_ENABLE 6
`define TSL_BIT_LINK_GROUP_EN 3
`define TSL_BIT_CLEAR_ON_READ 0

// reset values
`define TSL_RST_REG8 8'h00

// buffer and message geometry
`define TSL_BUF_DEPTH 96
`define TSL_PTR_FULL 7'h60
`define TSL_MSG_BYTES 7'h06
`define TSL_ELEM_LAST 3'h5
`define TSL_BIT_LAST 3'h5

`endif

// ### rtl/tsl_pkg.sv
package tsl_pkg;

  typedef enum logic [1:0] {
    TSL_IDLE = 2'b01,
    TSL_SEND = 2'b10
  } tsl_state_type;

endpackage

// ### rtl/tsl_fs_serializer.sv
`timescale 1ns/10ps
`include "tsl_consts.svh"

// walks the six elements of a message, six bits each, lsb first
module tsl_fs_serializer (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic slot_en,
  input wire logic restart,
  output logic [2:0] elem_idx_q,
  output logic [2:0] bit_idx_q,
  output logic msg_end
);

  assign msg_end = slot_en && (elem_idx_q == `TSL_ELEM_LAST) &&
                   (bit_idx_q == `TSL_BIT_LAST);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      elem_idx_q <= 3'h0;
      bit_idx_q <= 3'h0;
    end else if (restart || msg_end) begin
      elem_idx_q <= 3'h0;
      bit_idx_q <= 3'h0;
    end else if (slot_en) begin
      if (bit_idx_q == `TSL_BIT_LAST) begin
        bit_idx_q <= 3'h0;
        elem_idx_q <= elem_idx_q + 3'h1;
      end else begin
        bit_idx_q <= bit_idx_q + 3'h1;
      end
    end
  end

endmodule // tsl_fs_serializer

// ### rtl/tsl_tx_link_buffer.sv
`timescale 1ns/10ps
`include "tsl_consts.svh"

// Behaviour
// - byte count register bit 7 reads which ping-pong buffer is next free.
// - each buffer has its own data port, offsets 6 and 7.
// - port writes fill transmit buffer; port reads return receive buffer data.
// - first write lands at location 0, later writes advance, up to 96.
// - link irq enable bit 6 gates start-of-transfer interrupt.
// - block irq enable bit 3 gates all data link interrupts.
// - interrupt reaches host only when both enable bits are set.
// - status bit 6 sets when a newly loaded message starts going out; repeats of the last message do not set it.
// - status flag holds until software clears it, by a status read or a write-one.
// - clear-on-read clears flag on read; otherwise write-one clears it.
// - each element goes out lsb first in the alignment bit slots.
// - without a new message the last message repeats for as long as both link control enables stay set.
module tsl_tx_link_buffer (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic host_direct,
  input wire logic [3:0] host_page,
  input wire logic [7:0] host_addr,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata_q,
  output logic host_rd_ack_q,
  input wire logic [7:0] rx_msg_byte,
  output logic rx_msg_pop,
  input wire logic fs_slot,
  input wire logic fs_regular,
  output logic superframe_align_bit_q,
  output logic link_irq
);

  logic [7:0] mem_q [2][`TSL_BUF_DEPTH];
  logic [6:0] ptr_q [2];
  logic [1:0] fresh_q;
  logic buf_sel_q;
  logic active_q;
  logic has_msg_q;
  tsl_pkg::tsl_state_type state_q;
  tsl_pkg::tsl_state_type state_d;
  logic [7:0] link_control_q;
  logic [7:0] block_irq_enable_q;
  logic [7:0] link_irq_enable_q;
  logic [7:0] irq_control_q;
  logic tx_start_of_transfer_q;
  logic [2:0] elem_idx;
  logic [2:0] bit_idx;
  logic msg_end;
  logic boundary;
  logic load_new;
  logic tx_enabled;
  logic port_hit;
  logic port_buf;
  logic port_wr;
  logic ind_fr;
  logic ind_irq;
  logic status_rd;
  logic status_wc;
  logic [7:0] rd_mux;

  // register decode
  assign port_hit = host_direct &&
                    (host_addr[3:0] == `TSL_OFS_BUF0_PORT ||
                     host_addr[3:0] == `TSL_OFS_BUF1_PORT);
  assign port_buf = (host_addr[3:0] == `TSL_OFS_BUF1_PORT);
  assign port_wr = host_wr && port_hit;
  assign ind_fr = !host_direct && host_page == `TSL_PAGE_FRAMER;
  assign ind_irq = !host_direct && host_page == `TSL_PAGE_IRQ;
  assign status_rd = host_rd && ind_irq &&
                     host_addr == `TSL_OFS_LINK_STATUS;
  assign status_wc = host_wr && ind_irq &&
                     host_addr == `TSL_OFS_LINK_STATUS &&
                     host_wdata[`TSL_BIT_SOT_STATUS];
  // receive side lives outside; a port read consumes one of its bytes
  assign rx_msg_pop = host_rd && port_hit;

  // both enables needed; the host sets them
  assign tx_enabled = link_control_q[`TSL_BIT_MSG_MODE_EN] &&
                      link_control_q[`TSL_BIT_PACKET_EN];

  tsl_fs_serializer u_ser (
    .clk_sys(clk_sys),
    .rst(rst),
    .slot_en(fs_slot),
    .restart(fs_slot && state_q != tsl_pkg::TSL_SEND),
    .elem_idx_q(elem_idx),
    .bit_idx_q(bit_idx),
    .msg_end(msg_end)
  );

  // decisions are taken only between messages, so a message never tears
  assign boundary = (state_q == tsl_pkg::TSL_SEND) ? msg_end : fs_slot;
  assign load_new = boundary && tx_enabled && fresh_q[buf_sel_q];

  always_comb begin
    state_d = state_q;
    if (boundary) begin
      case (state_q)
        tsl_pkg::TSL_IDLE: begin
          if (tx_enabled && (fresh_q[buf_sel_q] || has_msg_q)) begin
            state_d = tsl_pkg::TSL_SEND;
          end
        end
        tsl_pkg::TSL_SEND: begin
          if (!tx_enabled) begin
            state_d = tsl_pkg::TSL_IDLE;
          end
        end
        default: begin
          state_d = tsl_pkg::TSL_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= tsl_pkg::TSL_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ping-pong selection
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      buf_sel_q <= 1'b0;
    end else if (load_new) begin
      buf_sel_q <= ~buf_sel_q;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      active_q <= 1'b0;
    end else if (load_new) begin
      active_q <= buf_sel_q;
    end
  end

  // once anything went out, an idle restart repeats it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      has_msg_q <= 1'b0;
    end else if (load_new) begin
      has_msg_q <= 1'b1;
    end
  end

  // message storage; data is not reset, software initialises it
  always_ff @(posedge clk_sys) begin
    if (port_wr && ptr_q[port_buf] < `TSL_PTR_FULL) begin
      mem_q[port_buf][ptr_q[port_buf]] <= host_wdata;
    end
  end

  // per-buffer write pointers and completeness flags
  genvar gb;
  generate
    for (gb = 0; gb < 2; gb = gb + 1) begin : g_buf
      logic hit;
      logic take;
      logic rearm;
      assign hit = port_wr && (port_buf == 1'(gb));
      assign take = load_new && (buf_sel_q == 1'(gb));
      // the buffer that just finished sending becomes the free one
      assign rearm = load_new && (buf_sel_q != 1'(gb));

      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          ptr_q[gb] <= 7'h00;
        end else if (rearm) begin
          ptr_q[gb] <= 7'h00;
        end else if (hit && ptr_q[gb] < `TSL_PTR_FULL) begin
          ptr_q[gb] <= ptr_q[gb] + 7'h01;
        end
      end

      // a buffer counts as loaded once a whole message is in it
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          fresh_q[gb] <= 1'b0;
        end else if (take || rearm) begin
          fresh_q[gb] <= 1'b0;
        end else if (hit && ptr_q[gb] == `TSL_MSG_BYTES - 7'h01) begin
          fresh_q[gb] <= 1'b1;
        end
      end
    end
  endgenerate

  // outbound alignment bit
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      superframe_align_bit_q <= 1'b0;
    end else if (fs_slot) begin
      if (state_q == tsl_pkg::TSL_SEND) begin
        superframe_align_bit_q <=
          mem_q[active_q][elem_idx][bit_idx];
      end else begin
        superframe_align_bit_q <= fs_regular;
      end
    end
  end

  // start-of-transfer flag, set wins over any clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tx_start_of_transfer_q <= 1'b0;
    end else if (load_new) begin
      tx_start_of_transfer_q <= 1'b1;
    end else if (status_rd && irq_control_q[`TSL_BIT_CLEAR_ON_READ]) begin
      tx_start_of_transfer_q <= 1'b0;
    end else if (status_wc &&
                 !irq_control_q[`TSL_BIT_CLEAR_ON_READ]) begin
      tx_start_of_transfer_q <= 1'b0;
    end
  end

  assign link_irq = tx_start_of_transfer_q &&
                    link_irq_enable_q[`TSL_BIT_SOT_ENABLE] &&
                    block_irq_enable_q[`TSL_BIT_LINK_GROUP_EN];

  // control registers, one process each
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      link_control_q <= `TSL_RST_REG8;
    end else if (host_wr && ind_fr &&
                 host_addr == `TSL_OFS_LINK_CONTROL) begin
      link_control_q <= host_wdata;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      block_irq_enable_q <= `TSL_RST_REG8;
    end else if (host_wr && ind_irq &&
                 host_addr == `TSL_OFS_BLOCK_IRQ_ENABLE) begin
      block_irq_enable_q <= host_wdata;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      link_irq_enable_q <= `TSL_RST_REG8;
    end else if (host_wr && ind_irq &&
                 host_addr == `TSL_OFS_LINK_IRQ_ENABLE) begin
      link_irq_enable_q <= host_wdata;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_control_q <= `TSL_RST_REG8;
    end else if (host_wr && ind_irq &&
                 host_addr == `TSL_OFS_IRQ_CONTROL) begin
      irq_control_q <= host_wdata;
    end
  end

  // read mux; unmapped reads return zero
  always_comb begin
    rd_mux = 8'h00;
    if (port_hit) begin
      rd_mux = rx_msg_byte;
    end else if (ind_fr && host_addr == `TSL_OFS_TX_LINK_BYTE_COUNT) begin
      rd_mux = {buf_sel_q, ptr_q[buf_sel_q]};
    end else if (ind_fr && host_addr == `TSL_OFS_LINK_CONTROL) begin
      rd_mux = link_control_q;
    end else if (ind_irq && host_addr == `TSL_OFS_BLOCK_IRQ_ENABLE) begin
      rd_mux = block_irq_enable_q;
    end else if (ind_irq && host_addr == `TSL_OFS_IRQ_CONTROL) begin
      rd_mux = irq_control_q;
    end else if (ind_irq && host_addr == `TSL_OFS_LINK_STATUS) begin
      rd_mux = 8'h00;
      rd_mux[`TSL_BIT_SOT_STATUS] = tx_start_of_transfer_q;
    end else if (ind_irq && host_addr == `TSL_OFS_LINK_IRQ_ENABLE) begin
      rd_mux = link_irq_enable_q;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      host_rd_ack_q <= 1'b0;
    end else begin
      host_rd_ack_q <= host_rd;
    end
  end

  // read data holds until the next read
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      host_rdata_q <= `TSL_RST_REG8;
    end else if (host_rd) begin
      host_rdata_q <= rd_mux;
    end
  end

endmodule // tsl_tx_link_buffer

// ### verif/tsl_tx_link_checker.sv
`timescale 1ns/10ps
module tsl_tx_link_checker (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic host_direct,
  input wire logic [3:0] host_page,
  input wire logic [7:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic [7:0] host_rdata_q,
  input wire logic host_rd_ack_q,
  input wire logic [7:0] rx_msg_byte,
  input wire logic rx_msg_pop,
  input wire logic fs_slot,
  input wire logic fs_regular,
  input wire logic superframe_align_bit_q,
  input wire logic link_irq
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // data ports are offsets 6 and 7, channel nibble ignored
  sequence s_port_rd;
    host_rd && host_direct && host_addr[3:1] == 3'h3;
  endsequence
  chk_ack_follows_rd: assert property (host_rd |=> host_rd_ack_q)
    else $error("read not acknowledged");
  chk_ack_no_spur: assert property (!host_rd |=> !host_rd_ack_q)
    else $error("acknowledge without read");
  chk_pop_on_port: assert property (s_port_rd |-> rx_msg_pop)
    else $error("port read without pop");
  chk_pop_only_rd: assert property (!host_rd |-> !rx_msg_pop)
    else $error("pop without read");
  chk_port_rdata: assert property
    (s_port_rd |=> host_rdata_q == $past(rx_msg_byte))
    else $error("port read data wrong");
  chk_irq_rise_cause: assert property ($rose(link_irq) |->
    $past(fs_slot) || $past(fs_slot, 2) || $past(host_wr))
    else $error("interrupt rose without cause");
  chk_irq_hold: assert property
    ($fell(link_irq) |-> $past(host_rd) || $past(host_wr))
    else $error("interrupt dropped on its own");
  chk_align_stable: assert property
    (!fs_slot |=> $stable(superframe_align_bit_q))
    else $error("line bit moved outside a slot");
endmodule // tsl_tx_link_checker

bind tsl_tx_link_buffer tsl_tx_link_checker u_chk (.clk_sys(clk_sys),
  .rst(rst), .host_wr(host_wr), .host_rd(host_rd),
  .host_direct(host_direct), .host_page(host_page), .host_addr(host_addr),
  .host_wdata(host_wdata), .host_rdata_q(host_rdata_q),
  .host_rd_ack_q(host_rd_ack_q), .rx_msg_byte(rx_msg_byte),
  .rx_msg_pop(rx_msg_pop), .fs_slot(fs_slot), .fs_regular(fs_regular),
  .superframe_align_bit_q(superframe_align_bit_q), .link_irq(link_irq));

// ### verif/tsl_host_model.sv
`timescale 1ns/10ps
// processor side: one strobe per access
module tsl_host_model (
  input wire logic clk_sys,
  output logic host_wr,
  output logic host_rd,
  output logic host_direct,
  output logic [3:0] host_page,
  output logic [7:0] host_addr,
  output logic [7:0] host_wdata,
  input wire logic [7:0] host_rdata_q,
  input wire logic host_rd_ack_q
);
  initial begin
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_direct = 1'b0;
    host_page = 4'h0;
    host_addr = 8'h00;
    host_wdata = 8'h00;
  end
  task automatic acc(input logic w, input logic d, input logic [3:0] p,
      input logic [7:0] a, input logic [7:0] v, output logic [7:0] q);
    @(posedge clk_sys);
    host_wr <= w;
    host_rd <= !w;
    host_direct <= d;
    host_page <= p;
    host_addr <= a;
    host_wdata <= v;
    @(posedge clk_sys);
    host_wr <= 1'b0;
    host_rd <= 1'b0;
    // released bus shows garbage so stale values never pass
    host_addr <= ~a;
    host_wdata <= ~v;
    // one more edge so a write has landed before the caller looks
    @(posedge clk_sys);
    q = w ? 8'h00 : (host_rd_ack_q ? host_rdata_q : 8'hxx);
  endtask
endmodule // tsl_host_model

// ### verif/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic clk_sys, rst, host_wr, host_rd, host_direct, host_rd_ack_q;
  logic [3:0] host_page;
  logic [7:0] host_addr, host_wdata, host_rdata_q, rx_msg_byte;
  logic rx_msg_pop, fs_slot, fs_regular, superframe_align_bit_q, link_irq;
  int n_fail, n_compared;
  logic [7:0] m0 [6] = '{8'h2b, 8'h29, 8'h15, 8'h3c, 8'h0a, 8'h33};
  logic [7:0] m1 [6] = '{8'h14, 8'h16, 8'h2a, 8'h03, 8'h35, 8'h0c};
  tsl_tx_link_buffer DUT (.clk_sys(clk_sys), .rst(rst), .host_wr(host_wr),
    .host_rd(host_rd), .host_direct(host_direct), .host_page(host_page),
    .host_addr(host_addr), .host_wdata(host_wdata),
    .host_rdata_q(host_rdata_q), .host_rd_ack_q(host_rd_ack_q),
    .rx_msg_byte(rx_msg_byte), .rx_msg_pop(rx_msg_pop), .fs_slot(fs_slot),
    .fs_regular(fs_regular), .superframe_align_bit_q(superframe_align_bit_q),
    .link_irq(link_irq));
  tsl_host_model host (.clk_sys(clk_sys), .host_wr(host_wr),
    .host_rd(host_rd), .host_direct(host_direct), .host_page(host_page),
    .host_addr(host_addr), .host_wdata(host_wdata),
    .host_rdata_q(host_rdata_q), .host_rd_ack_q(host_rd_ack_q));
  always #5 clk_sys = ~clk_sys;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic d, input logic [3:0] p, input logic [7:0] a,
      input logic [7:0] v);
    logic [7:0] q;
    host.acc(1'b1, d, p, a, v, q);
  endtask
  task automatic rd(input logic d, input logic [3:0] p, input logic [7:0] a,
      input logic [7:0] e);
    logic [7:0] q;
    host.acc(1'b0, d, p, a, 8'h00, q);
    chk(q, e);
  endtask
  task automatic slot(input logic e);
    @(posedge clk_sys);
    fs_slot <= 1'b1;
    @(posedge clk_sys);
    fs_slot <= 1'b0;
    @(posedge clk_sys);
    chk({7'h00, superframe_align_bit_q}, {7'h00, e});
  endtask
  task automatic msg(input logic [7:0] m [6], input int lo, input int hi);
    for (int i = lo; i <= hi; i++)
      for (int b = 0; b < 6; b++)
        slot(m[i][b]);
  endtask
  task automatic fill(input logic [3:0] port, input logic [7:0] m [6]);
    for (int i = 0; i < 6; i++)
      wr(1'b1, 4'h0, {4'h0, port}, {2'b00, m[i][5:0]});
  endtask
  task automatic results;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    fs_slot = 1'b0;
    fs_regular = 1'b1;
    rx_msg_byte = 8'h00;
    n_fail = 0;
    n_compared = 0;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    rd(1'b0, 4'h0, 8'h14, 8'h00);
    rd(1'b0, 4'ha, 8'h06, 8'h00);
    rd(1'b0, 4'ha, 8'h55, 8'h00);
    $display("test reset done");
    wr(1'b0, 4'h0, 8'h13, 8'h81);
    wr(1'b0, 4'ha, 8'h07, 8'h40);
    wr(1'b0, 4'ha, 8'h00, 8'h08);
    rd(1'b0, 4'ha, 8'h07, 8'h40);
    rd(1'b0, 4'ha, 8'h00, 8'h08);
    fill(4'h6, m0);
    rd(1'b0, 4'h0, 8'h14, 8'h06);
    wr(1'b0, 4'h0, 8'h14, 8'hff);
    rd(1'b0, 4'h0, 8'h14, 8'h06);
    slot(1'b1);
    chk({7'h00, link_irq}, 8'h01);
    rd(1'b0, 4'h0, 8'h14, 8'h80);
    msg(m0, 0, 5);
    $display("test first message done");
    rd(1'b0, 4'ha, 8'h06, 8'h40);
    rd(1'b0, 4'ha, 8'h06, 8'h40);
    wr(1'b0, 4'ha, 8'h00, 8'h00);
    chk({7'h00, link_irq}, 8'h00);
    wr(1'b0, 4'ha, 8'h00, 8'h08);
    chk({7'h00, link_irq}, 8'h01);
    wr(1'b0, 4'ha, 8'h06, 8'h40);
    rd(1'b0, 4'ha, 8'h06, 8'h00);
    chk({7'h00, link_irq}, 8'h00);
    $display("test status clear done");
    msg(m0, 0, 2);
    wr(1'b0, 4'ha, 8'h01, 8'h01);
    fill(4'h7, m1);
    rd(1'b0, 4'h0, 8'h14, 8'h86);
    msg(m0, 3, 5);
    msg(m1, 0, 5);
    rd(1'b0, 4'h0, 8'h14, 8'h00);
    rd(1'b0, 4'ha, 8'h06, 8'h40);
    rd(1'b0, 4'ha, 8'h06, 8'h00);
    $display("test ping-pong done");
    @(posedge clk_sys);
    rx_msg_byte <= 8'h5a;
    rd(1'b1, 4'h0, 8'h07, 8'h5a);
    $display("test port read done");
    results();
  end
endmodule // testbench
